//--- src/wsc_regs.svh
// constants for the write strobe controller
`ifndef WSC_REGS_SVH
`define WSC_REGS_SVH
`define WSC_BANDS          8
`define WSC_BAND_W         3
`define WSC_CNT_W          7
`define WSC_LAT_W          6
`define WSC_TERM_OFF       3'h0
`define WSC_ZERO_CNT       7'h00
`define WSC_ONE_CNT        7'h01
`define WSC_POST_CLKS      7'h01
`define WSC_BURST_CLKS     7'h08
`define WSC_RD_BURST_CLKS  7'h09
`define WSC_PREAMBLE_CLKS  7'h02
`define WSC_TURNAROUND_CLKS 7'h02
`define WSC_WINDOW_TOL_QCK 2'h1
`endif

//--- src/wsc_pkg.sv
// types for the write strobe controller
`default_nettype none
`include "wsc_regs.svh"
package wsc_pkg;
  typedef enum logic {
    WSC_MODE_READ_BASED,
    WSC_MODE_WINDOW
  } wsc_mode_t;

  typedef struct packed {
    logic t_o;
    logic t_oe_n;
    logic c_o;
    logic c_oe_n;
  } wsc_strobe_t;

  typedef struct packed {
    logic [`WSC_CNT_W-1:0] on_dly;
    logic [`WSC_CNT_W-1:0] off_dly;
  } wsc_window_t;
endpackage
`default_nettype wire

//--- src/wsc_delay_table.sv
// strobe on/off delay lookup by frequency band and latency set
`default_nettype none
`include "wsc_regs.svh"
module wsc_delay_table
  import wsc_pkg::*;
(
  input  wire logic                   clk,      // system clock
  input  wire logic                   rstn,     // sync reset, low
  input  wire logic [`WSC_BAND_W-1:0] band,     // frequency band
  input  wire logic                   set_b,    // latency set b
  output var wsc_window_t             win       // registered delays
);
  wsc_window_t win_ff;
  wsc_window_t nxt_win;

  function automatic wsc_window_t look(input logic [2:0] b, input logic s);
    wsc_window_t r;
    r = '0;
    case (b)
      3'h0: r = '{7'h00, 7'h0F};
      3'h1: r = s ? '{7'h00, 7'h14} : '{7'h00, 7'h12};
      3'h2: r = s ? '{7'h06, 7'h19} : '{7'h00, 7'h15};
      3'h3: r = s ? '{7'h0C, 7'h20} : '{7'h04, 7'h18};
      3'h4: r = s ? '{7'h0E, 7'h25} : '{7'h04, 7'h1B};
      3'h5: r = s ? '{7'h12, 7'h2A} : '{7'h06, 7'h1E};
      3'h6: r = s ? '{7'h14, 7'h2F} : '{7'h06, 7'h21};
      default: r = s ? '{7'h18, 7'h34} : '{7'h08, 7'h24};
    endcase
    return r;
  endfunction

  always_comb begin
    nxt_win = look(band, set_b);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      win_ff <= '0;
    end else begin
      win_ff <= nxt_win;
    end
  end

  assign win = win_ff;
endmodule
`default_nettype wire

//--- src/wsc_sync.sv
// two-flop synchroniser for pin level inputs
`default_nettype none
module wsc_sync (
  input  wire logic clk,   // system clock
  input  wire logic rstn,  // sync reset, low
  input  wire logic d,     // async level
  output logic      q      // synchronised level
);
  logic s1_ff;
  logic s2_ff;
  logic nxt_s1;
  logic nxt_s2;

  always_comb begin
    nxt_s1 = d;
    nxt_s2 = s1_ff;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  assign q = s2_ff;
endmodule
`default_nettype wire

//--- src/wsc_strobe_ctrl.sv
// host write strobe controller: parking and on/off window control
`default_nettype none
`include "wsc_regs.svh"
module wsc_strobe_ctrl
  import wsc_pkg::*;
(
  input  wire logic                   clk,        // system clock 100 MHz
  input  wire logic                   rstn,       // sync reset, low
  input  wire logic                   mode_win,   // 1 window mode
  input  wire logic [`WSC_BAND_W-1:0] band,       // frequency band
  input  wire logic                   set_b,      // latency set b
  input  wire logic [2:0]             term_sel,   // termination select
  input  wire logic [`WSC_LAT_W-1:0]  write_latency, // write latency
  input  wire logic [`WSC_CNT_W-1:0]  rtw_extra,  // gap beyond minimum
  input  wire logic                   cke,        // clock enable pin
  input  wire logic                   dram_clk,   // link clock pin
  input  wire logic                   wr_cmd,     // write issued
  input  wire logic                   rd_cmd,     // read issued
  input  wire logic                   train_hold, // training priority
  input  wire logic                   dqs_t_i,    // true strobe pin in
  input  wire logic                   dqs_c_i,    // compl strobe pin in
  output logic                        dqs_t_o,    // true strobe out
  output logic                        dqs_t_oe_n, // true drive, low
  output logic                        dqs_c_o,    // compl strobe out
  output logic                        dqs_c_oe_n, // compl drive, low
  output logic                        wr_busy,    // strobe window active
  output logic                        exc_active, // exception period
  output logic                        term_on     // termination enabled
);
  typedef enum logic [2:0] {
    WSC_IDLE, WSC_PARK, WSC_PRE, WSC_BURST, WSC_HOLD, WSC_READ, WSC_TURN
  } wsc_state_t;

  wsc_window_t win;
  logic cke_s;
  logic lclk_s;
  logic unused_pins;
  logic dqs_t_s;
  logic dqs_c_s;

  wsc_delay_table u_tab (
    .clk   (clk),
    .rstn  (rstn),
    .band  (band),
    .set_b (set_b),
    .win   (win)
  );

  wsc_sync u_cke (
    .clk  (clk),
    .rstn (rstn),
    .d    (cke),
    .q    (cke_s)
  );

  wsc_sync u_lclk (
    .clk  (clk),
    .rstn (rstn),
    .d    (dram_clk),
    .q    (lclk_s)
  );

  // strobe pins come from the far side: synchronise before any use
  wsc_sync u_dqs_t (
    .clk  (clk),
    .rstn (rstn),
    .d    (dqs_t_i),
    .q    (dqs_t_s)
  );

  wsc_sync u_dqs_c (
    .clk  (clk),
    .rstn (rstn),
    .d    (dqs_c_i),
    .q    (dqs_c_s)
  );

  assign unused_pins = dqs_t_s ^ dqs_c_s;

  function automatic logic [`WSC_CNT_W-1:0] sat_dec(
    input logic [`WSC_CNT_W-1:0] v);
    return (v == `WSC_ZERO_CNT) ? v : v - `WSC_ONE_CNT;
  endfunction

  // both pins driven, complement opposite to true
  function automatic wsc_strobe_t diff_pins(input logic lvl);
    wsc_strobe_t p;
    p.t_o    = lvl;
    p.t_oe_n = 1'b0;
    p.c_o    = ~lvl;
    p.c_oe_n = 1'b0;
    return p;
  endfunction

  // both pins released
  function automatic wsc_strobe_t off_pins();
    wsc_strobe_t p;
    p.t_o    = 1'b0;
    p.t_oe_n = 1'b1;
    p.c_o    = 1'b0;
    p.c_oe_n = 1'b1;
    return p;
  endfunction

  wsc_state_t              st_ff;
  wsc_state_t              nxt_st;
  logic                    lclk_ff;
  logic                    nxt_lclk;
  logic [`WSC_CNT_W-1:0]   cnt_ff;
  logic [`WSC_CNT_W-1:0]   nxt_cnt;
  logic [`WSC_CNT_W-1:0]   off_ff;
  logic [`WSC_CNT_W-1:0]   nxt_off;
  logic [`WSC_CNT_W-1:0]   exc_ff;
  logic [`WSC_CNT_W-1:0]   nxt_exc;
  logic                    tog_ff;
  logic                    nxt_tog;
  wsc_strobe_t             pin_ff;
  wsc_strobe_t             nxt_pin;
  logic                    busy_ff;
  logic                    nxt_busy;
  logic                    lrise;
  logic [`WSC_CNT_W:0]     exc_calc;

  // burst starts and toggles align to sampled link rises
  assign lrise = lclk_s & ~lclk_ff;

  always_comb begin
    // exception: termination on gives turnaround, else the formula
    exc_calc = {1'b0, 7'(write_latency)} - {1'b0, win.on_dly}
             + {1'b0, `WSC_TURNAROUND_CLKS} - {1'b0, `WSC_PREAMBLE_CLKS}
             - {1'b0, rtw_extra};
    if (term_sel != `WSC_TERM_OFF) begin
      nxt_exc = `WSC_TURNAROUND_CLKS;
    end else if (exc_calc[`WSC_CNT_W]) begin
      nxt_exc = `WSC_ZERO_CNT;
    end else begin
      nxt_exc = exc_calc[`WSC_CNT_W-1:0];
    end
  end

  always_comb begin
    nxt_lclk = lclk_s;
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_off  = off_ff;
    nxt_tog  = tog_ff;
    nxt_pin  = pin_ff;
    nxt_busy = busy_ff;
    if (lrise) begin
      nxt_cnt = sat_dec(cnt_ff);
      nxt_off = sat_dec(off_ff);
    end
    if (wr_cmd && !train_hold) begin
      // rearm off window from the last write
      // spare count covers a link rise caught just before the write
      nxt_off  = win.off_dly + `WSC_ONE_CNT;
      nxt_busy = 1'b1;
    end
    case (st_ff)
      WSC_IDLE: begin
        nxt_st = WSC_PARK;
      end
      WSC_PARK, WSC_HOLD: begin
        if (wr_cmd && !train_hold) begin
          nxt_st = WSC_PRE;
          nxt_cnt = `WSC_PREAMBLE_CLKS;
        end else if (rd_cmd) begin
          nxt_st  = WSC_READ;
          nxt_cnt = `WSC_RD_BURST_CLKS;
        end else if (st_ff == WSC_HOLD && off_ff == `WSC_ZERO_CNT) begin
          nxt_st   = WSC_PARK;
          nxt_busy = 1'b0;
        end
      end
      WSC_PRE: begin
        if (lrise && cnt_ff <= `WSC_ONE_CNT) begin
          nxt_st  = WSC_BURST;
          nxt_cnt = `WSC_BURST_CLKS + `WSC_POST_CLKS;
        end
      end
      WSC_BURST: begin
        if (lrise) begin
          nxt_tog = ~tog_ff;
        end
        if (wr_cmd && !train_hold) begin
          nxt_cnt = `WSC_BURST_CLKS + `WSC_POST_CLKS;
        end else if (lrise && cnt_ff <= `WSC_ONE_CNT) begin
          nxt_st = WSC_HOLD;
        end
      end
      WSC_READ: begin
        if (lrise && cnt_ff <= `WSC_ONE_CNT) begin
          nxt_st  = WSC_TURN;
          nxt_cnt = exc_ff;
        end
      end
      WSC_TURN: begin
        if (cnt_ff == `WSC_ZERO_CNT) begin
          nxt_st = busy_ff ? WSC_HOLD : WSC_PARK;
        end else if (wr_cmd && !train_hold) begin
          nxt_st  = WSC_PRE;
          nxt_cnt = `WSC_PREAMBLE_CLKS;
        end
      end
      default: nxt_st = WSC_PARK;
    endcase

    // pin drive per state
    nxt_pin = off_pins();
    if (!cke_s) begin
      nxt_pin = off_pins();
    end else begin
      case (nxt_st)
        WSC_PARK: begin
          if (!mode_win) begin
            nxt_pin = diff_pins(1'b0);
          end
        end
        // differential at once, inside any on delay maximum
        WSC_PRE: nxt_pin = diff_pins(1'b0);
        WSC_BURST: begin
          nxt_pin = diff_pins(nxt_tog);
        end
        WSC_HOLD: begin
          // complement stays high in either mode until the window ends
          nxt_pin = diff_pins(1'b0);
        end
        WSC_READ, WSC_TURN: begin
          nxt_pin = off_pins();
        end
        default: nxt_pin = off_pins();
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff   <= WSC_IDLE;
      lclk_ff <= 1'b0;
      cnt_ff  <= `WSC_ZERO_CNT;
      off_ff  <= `WSC_ZERO_CNT;
      exc_ff  <= `WSC_ZERO_CNT;
      tog_ff  <= 1'b0;
      pin_ff  <= '{1'b0, 1'b1, 1'b0, 1'b1};
      busy_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      lclk_ff <= nxt_lclk;
      cnt_ff  <= nxt_cnt;
      off_ff  <= nxt_off;
      exc_ff  <= nxt_exc;
      tog_ff  <= nxt_tog;
      pin_ff  <= nxt_pin;
      busy_ff <= nxt_busy;
    end
  end

  assign dqs_t_o    = pin_ff.t_o;
  assign dqs_t_oe_n = pin_ff.t_oe_n;
  assign dqs_c_o    = pin_ff.c_o;
  assign dqs_c_oe_n = pin_ff.c_oe_n;
  assign wr_busy    = busy_ff;
  assign exc_active = (st_ff == WSC_TURN);
  assign term_on    = (term_sel != `WSC_TERM_OFF);
endmodule
`default_nettype wire

//--- tb/wsc_chk.sv
// port assertions for the write strobe controller
`default_nettype none
module wsc_chk (
  input wire logic       clk,        // clock
  input wire logic       rstn,       // reset
  input wire logic       mode_win,   // mode
  input wire logic [2:0] term_sel,   // odt field
  input wire logic       cke,        // enable
  input wire logic       wr_cmd,     // write
  input wire logic       train_hold, // training
  input wire logic       dqs_t_o,    // true
  input wire logic       dqs_t_oe_n, // true en
  input wire logic       dqs_c_o,    // compl
  input wire logic       dqs_c_oe_n, // compl en
  input wire logic       wr_busy,    // busy
  input wire logic       term_on     // odt on
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] idle_ff;
  logic [10:0] nxt_idle;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // clocks of busy since the last write
  always_comb begin
    nxt_idle = (!rstn || wr_cmd || !wr_busy) ? 11'h000 : idle_ff + 11'h001;
  end
  always_ff @(posedge clk) begin
    idle_ff <= nxt_idle;
  end
  sequence parked_s;
    !mode_win && !wr_busy && !dqs_c_oe_n && dqs_c_o;
  endsequence
  sequence diff_s;
    !dqs_t_oe_n && !dqs_c_oe_n && (dqs_t_o != dqs_c_o);
  endsequence
  term_map_a: assert property (term_on == (term_sel != 3'h0))
    else $error("termination flag mismatch");
  cke_release_a: assert property (
    !cke [*6] |-> dqs_t_oe_n && dqs_c_oe_n)
    else $error("pins driven with clock enable low");
  park_start_a: assert property (
    parked_s ##0 (wr_cmd && !train_hold) |=> wr_busy)
    else $error("write not started from park");
  diff_start_a: assert property (
    parked_s ##1 $rose(wr_busy) |=> diff_s)
    else $error("pair not differential after write");
  train_block_a: assert property (
    wr_cmd && train_hold && !wr_busy |=> !wr_busy)
    else $error("write started during training");
  busy_diff_a: assert property (wr_busy && !dqs_t_oe_n |-> diff_s)
    else $error("pair not differential in window");
  repark_a: assert property (
    $fell(wr_busy) && !mode_win && cke |=>
      !dqs_c_oe_n && dqs_c_o && !dqs_t_oe_n && !dqs_t_o)
    else $error("complement not parked high");
  busy_min_a: assert property ($rose(wr_busy) |-> wr_busy [*8])
    else $error("window closed too early");
  busy_max_a: assert property (idle_ff < 11'h44C)
    else $error("window never closes");
endmodule
bind wsc_strobe_ctrl wsc_chk wsc_chk_inst (.clk, .rstn, .mode_win,
  .term_sel, .cke, .wr_cmd, .train_hold, .dqs_t_o, .dqs_t_oe_n, .dqs_c_o,
  .dqs_c_oe_n, .wr_busy, .term_on);
`default_nettype wire

//--- tb/wsc_dram_model.sv
// behavioural memory device: link clock, strobe wires, termination
`default_nettype none
module wsc_dram_model (
  input  wire logic       clk,        // bench clock
  input  wire logic       rd_cmd,     // read issued
  input  wire logic [2:0] term_sel,   // odt field
  input  wire logic       cke,        // enable
  input  wire logic       dqs_t_o,    // host true
  input  wire logic       dqs_t_oe_n, // host true en
  input  wire logic       dqs_c_o,    // host compl
  input  wire logic       dqs_c_oe_n, // host compl en
  output logic            dram_clk,   // link clock
  output logic            dqs_t_i,    // true wire
  output logic            dqs_c_i,    // compl wire
  output logic            rtt_on      // termination on
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lt = 1'b0, lc = 1'b0, tg = 1'b0, pk = 1'b0;
  int   rd_left = 0;
  initial begin
    dram_clk = 1'b0;
    forever #80 dram_clk = ~dram_clk;
  end
  assign rtt_on = term_sel != 3'h0;
  always @(posedge dram_clk) tg <= ~tg;
  always @(posedge clk) begin
    pk <= dram_clk;
    if (cke && !dqs_t_oe_n) lt <= dqs_t_o;
    if (cke && !dqs_c_oe_n) lc <= dqs_c_o;
    if (rd_cmd) rd_left <= 9;
    else if (dram_clk && !pk && rd_left > 0) rd_left <= rd_left - 1;
  end
  // released wires show the read strobe or the inverse of the last level
  assign dqs_t_i = !dqs_t_oe_n ? dqs_t_o : rd_left > 0 ? tg : ~lt;
  assign dqs_c_i = !dqs_c_oe_n ? dqs_c_o : rd_left > 0 ? ~tg : ~lc;
endmodule
`default_nettype wire

//--- tb/tb_wsc_strobe_ctrl.sv
// self-checking bench for the write strobe controller
`default_nettype none
module tb_wsc_strobe_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rstn = 1'b0, mode_win = 1'b0, set_b = 1'b0, cke = 1'b1;
  logic [2:0] band = 3'h0, term_sel = 3'h0;
  logic [5:0] write_latency = 6'h08;
  logic [6:0] rtw_extra = 7'h03;
  logic wr_cmd = 1'b0, rd_cmd = 1'b0, train_hold = 1'b0;
  logic dram_clk, dqs_t_i, dqs_c_i, dqs_t_o, dqs_t_oe_n, dqs_c_o, dqs_c_oe_n;
  logic wr_busy, exc_active, term_on, rtt_on;
  int num_errors = 0, compares = 0, links = 0;
  // per band: on delay a, on delay b, off delay a, off delay b
  int rows[8][4] = '{'{0,0,15,15}, '{0,0,18,20}, '{0,6,21,25},
    '{4,12,24,32}, '{4,14,27,37}, '{6,18,30,42}, '{6,20,33,47},
    '{8,24,36,52}};
  wsc_strobe_ctrl wsc_strobe_ctrl_inst (.clk, .rstn, .mode_win, .band,
    .set_b, .term_sel, .write_latency, .rtw_extra, .cke, .dram_clk, .wr_cmd,
    .rd_cmd, .train_hold, .dqs_t_i, .dqs_c_i, .dqs_t_o, .dqs_t_oe_n,
    .dqs_c_o, .dqs_c_oe_n, .wr_busy, .exc_active, .term_on);
  wsc_dram_model wsc_dram_model_inst (.clk, .rd_cmd, .term_sel, .cke,
    .dqs_t_o, .dqs_t_oe_n, .dqs_c_o, .dqs_c_oe_n, .dram_clk, .dqs_t_i,
    .dqs_c_i, .rtt_on);
  always @(posedge dram_clk) links++;
  task automatic results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tmo(input int t, lim);
    if (t >= lim) begin
      check("wait bound", 1'h0, 1'h1);
      results();
    end
  endtask
  task automatic pulse_wr;
    wr_cmd = 1'b1;
    @(negedge clk);
    wr_cmd = 1'b0;
  endtask
  task automatic do_write(input int on, off);
    int t, s;
    s = links;
    pulse_wr();
    for (t = 0; t < 999 && (dqs_t_oe_n !== 1'b0 || dqs_t_o === dqs_c_o); t++)
      @(negedge clk);
    tmo(t, 999);
    check("on delay", 1'h1, links - s <= on + 1);
    for (t = 0; t < 3000 && wr_busy !== 1'b0; t++)
      @(negedge clk);
    tmo(t, 3000);
    check("off min", 1'h1, links - s >= off);
    check("off band", 1'h1, links - s <= off + 2);
    repeat (4) @(negedge clk);
  endtask
  task automatic rd_exc(input int e);
    int t, s;
    rd_cmd = 1'b1;
    @(negedge clk);
    rd_cmd = 1'b0;
    repeat (3) @(negedge clk);
    check("read release", 1'h1, dqs_c_oe_n);
    for (t = 0; t < 400 && exc_active !== 1'b1; t++)
      @(negedge clk);
    tmo(t, 400);
    s = links;
    for (t = 0; t < 400 && exc_active !== 1'b0; t++)
      @(negedge clk);
    tmo(t, 400);
    check("exception", 1'h1, links - s >= e && links - s <= e + 1);
    repeat (4) @(negedge clk);
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (6) @(negedge clk);
    check("reset t", 1'h1, dqs_t_oe_n);
    check("reset busy", 1'h0, wr_busy);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    for (int s = 0; s < 2; s++)
      for (int b = 0; b < 8; b++) begin
        band = b[2:0];
        set_b = s[0];
        mode_win = b[0];
        term_sel = b[2:0];
        repeat (4) @(negedge clk);
        check("term", rtt_on, term_on);
        do_write(rows[b][s], rows[b][s + 2]);
      end
    mode_win = 1'b0;
    band = 3'h0;
    term_sel = 3'h0;
    repeat (4) @(negedge clk);
    rd_exc(5);
    term_sel = 3'h1;
    rd_exc(2);
    train_hold = 1'b1;
    pulse_wr();
    repeat (6) @(negedge clk);
    check("train refuse", 1'h0, wr_busy);
    train_hold = 1'b0;
    cke = 1'b0;
    repeat (8) @(negedge clk);
    check("cke release", 1'h1, dqs_c_oe_n);
    cke = 1'b1;
    repeat (8) @(negedge clk);
    check("park level", 1'h1, dqs_c_o);
    // reset in the middle of a write preamble
    pulse_wr();
    repeat (3) @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    check("mid reset busy", 1'h0, wr_busy);
    check("mid reset c", 1'h1, dqs_c_oe_n);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    check("repark drive", 1'h0, dqs_c_oe_n);
    check("repark level", 1'h1, dqs_c_o);
    results();
  end
endmodule
`default_nettype wire
